/* File: rtl/sas_pkg.sv */
// Shared constants, types and helpers of the converter sequencer
package sas_pkg;

   // Widths
   localparam int RES_W = 10;
   localparam int SEL_W = 6;
   localparam int REF_W = 2;
   localparam int PS_W = 3;
   localparam int TS_W = 3;
   localparam int HC_W = 6;
   localparam int PS_CNT_W = 8;
   localparam int BIT_W = 4;
   localparam int TRIG_SYNC_CYCLES = 3;

   // Conversion timing in converter half cycles from the start of a conversion
   localparam logic [HC_W-1:0] HC_DONE_NORMAL = 6'h1a;
   localparam logic [HC_W-1:0] HC_DONE_FIRST = 6'h32;
   localparam logic [HC_W-1:0] HC_DONE_AUTO = 6'h1b;
   localparam logic [HC_W-1:0] HC_SH_NORMAL = 6'h03;
   localparam logic [HC_W-1:0] HC_SH_FIRST = 6'h1d;
   localparam logic [HC_W-1:0] HC_SH_AUTO = 6'h04;
   localparam logic [HC_W-1:0] HC_LAST_CYCLE = 6'h02;
   localparam logic [HC_W-1:0] HC_ONE = 6'h01;

   // Successive approximation start point
   localparam logic [RES_W-1:0] SAR_MSB_TRIAL = 10'h200;
   localparam logic [BIT_W-1:0] SAR_MSB_INDEX = 4'h9;
   localparam logic [BIT_W-1:0] SAR_LSB_INDEX = 4'h0;

   // Input selection codes
   localparam logic [SEL_W-1:0] TEMP_SENSOR_CODE = 6'h22;
   localparam logic [SEL_W-1:0] SINGLE_ENDED_LIMIT = 6'h08;
   localparam logic [REF_W-1:0] REF_SUPPLY = 2'h0;
   localparam logic [REF_W-1:0] REF_EXTERNAL = 2'h1;
   localparam logic [REF_W-1:0] REF_INTERNAL = 2'h2;

   // Trigger source code that selects back-to-back conversions
   localparam logic [TS_W-1:0] TRIG_FREE_RUN = 3'h0;

   // Sequencer states
   typedef enum logic [2:0] {
      SAS_IDLE = 3'b001,
      SAS_WAIT = 3'b010,
      SAS_CONV = 3'b100
   } sas_state_t;

   // Converter clock division ratio for a prescaler select code
   function automatic logic [PS_CNT_W-1:0] sas_ratio(input logic [PS_W-1:0] sel);
      sas_ratio = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
   endfunction

   // Half cycle at which a conversion completes
   function automatic logic [HC_W-1:0] sas_done_at(input logic first, input logic auto_t);
      sas_done_at = first ? HC_DONE_FIRST : (auto_t ? HC_DONE_AUTO : HC_DONE_NORMAL);
   endfunction

   // Half cycle at which the input is sampled
   function automatic logic [HC_W-1:0] sas_sh_at(input logic first, input logic auto_t);
      sas_sh_at = first ? HC_SH_FIRST : (auto_t ? HC_SH_AUTO : HC_SH_NORMAL);
   endfunction

endpackage

/* File: rtl/sas_ck_if.sv */
// Converter clock enables between the prescaler and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface sas_ck_if;
   logic enable;
   logic [sas_pkg::PS_W-1:0] ratio_sel;
   logic restart;
   logic rise;
   logic fall;
   modport src (input enable, input ratio_sel, input restart, output rise, output fall);
   modport snk (output enable, output ratio_sel, output restart, input rise, input fall);
endinterface
`default_nettype wire

/* File: rtl/sas_prescaler.sv */
// Converter clock prescaler producing rise and fall enable pulses
`timescale 1ns/1ps
`default_nettype none
module sas_prescaler (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Converter clock enables
   sas_ck_if.src ck
);
   logic [sas_pkg::PS_CNT_W-1:0] cnt_q;
   logic [sas_pkg::PS_CNT_W-1:0] cnt_d;
   wire logic [sas_pkg::PS_CNT_W-1:0] ratio = sas_pkg::sas_ratio(ck.ratio_sel);
   wire logic at_end = (cnt_q == ratio - 8'h01);
   wire logic at_half = (cnt_q == (ratio >> 1) - 8'h01);

   // Held at zero while disabled, restarted by a trigger
   assign cnt_d = (!ck.enable || ck.restart || at_end) ? 8'h00 : cnt_q + 8'h01;
   assign ck.rise = ck.enable && !ck.restart && at_end;
   assign ck.fall = ck.enable && !ck.restart && at_half;

   // Counter register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // No converter edges while disabled
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   a_held_disabled: assert property (!ck.enable |=> cnt_q == 8'h00 && !ck.rise)
      else $error("prescaler ran while converter disabled");

endmodule
`default_nettype wire

/* File: rtl/sas_sequencer.sv */
// Sequencer of the 10-bit successive approximation converter
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer #(
   parameter int TRIG_W = 8,
   parameter logic [5:0] OFFSET_CODE_A = 6'h08,
   parameter logic [5:0] OFFSET_CODE_B = 6'h09,
   parameter logic [5:0] OFFSET_CODE_C = 6'h0a
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Software control bits
   input wire logic converter_enable,
   input wire logic auto_trigger_enable,
   input wire logic left_adjust,
   input wire logic [sas_pkg::PS_W-1:0] prescaler_select,
   input wire logic [sas_pkg::TS_W-1:0] trigger_source_select,
   input wire logic [sas_pkg::REF_W-1:0] reference_select,
   input wire logic [sas_pkg::SEL_W-1:0] channel_gain_select,
   // Software strobes, one cycle each
   input wire logic start_write,
   input wire logic done_flag_clear,
   input wire logic read_low_byte,
   input wire logic read_high_byte,
   // Trigger sources from on-chip logic
   input wire logic [TRIG_W-1:0] trigger_sources,
   // Analog comparator, asynchronous
   input wire logic comparator_high,
   // Software visible state
   output logic [7:0] result_high_byte,
   output logic [7:0] result_low_byte,
   output logic start_conversion_bit,
   output logic conversion_done_flag,
   // Analog front end control
   output logic analog_enable,
   output logic sample_hold,
   output logic [sas_pkg::RES_W-1:0] sar_trial_code,
   output logic [2:0] reference_onehot,
   output logic [sas_pkg::SEL_W-1:0] active_channel,
   output logic differential_mode,
   output logic gain_select_bit,
   output logic temp_sensor_route,
   output logic offset_measure
);
   if (TRIG_W < 8) begin : g_chk
      $error("trigger source vector narrower than the select range");
   end

   sas_ck_if ck ();
   sas_prescaler u_prescaler (
      .clock(clock),
      .nrst(nrst),
      .ck(ck.src)
   );

   sas_pkg::sas_state_t state_q, state_d;
   logic cmp_s1_q, cmp_s2_q;
   logic trig_prev_q, lock_q, first_q, auto_q, sar_on_q;
   logic lock_d, first_d, sar_on_d, start_d, flag_d;
   logic [sas_pkg::TRIG_SYNC_CYCLES-1:0] trig_dly_q;
   logic [sas_pkg::HC_W-1:0] hc_q, hc_d;
   logic [sas_pkg::BIT_W-1:0] bit_q, bit_d;
   logic [sas_pkg::RES_W-1:0] trial_d;
   logic [sas_pkg::REF_W-1:0] ref_q;
   logic [sas_pkg::SEL_W-1:0] chan_d;
   logic [sas_pkg::REF_W-1:0] ref_d;
   logic [7:0] high_d, low_d;

   // Prescaler hookup; the trigger restart aligns the converter clock
   assign ck.enable = converter_enable;
   assign ck.ratio_sel = prescaler_select;
   wire logic pulse = ck.rise || ck.fall;

   // Trigger selection and edge detection
   wire logic free_run = auto_trigger_enable &&
                         (trigger_source_select == sas_pkg::TRIG_FREE_RUN);
   wire logic trig_level = (trigger_source_select == sas_pkg::TRIG_FREE_RUN) ?
                           conversion_done_flag : trigger_sources[trigger_source_select];
   wire logic trig_edge = auto_trigger_enable && trig_level && !trig_prev_q;
   wire logic trig_take = trig_edge && !free_run && converter_enable &&
                          (state_q != sas_pkg::SAS_CONV) && (trig_dly_q == '0);
   wire logic trig_go = trig_dly_q[sas_pkg::TRIG_SYNC_CYCLES-1] && converter_enable;
   assign ck.restart = trig_go;

   // Conversion timing decode
   wire logic in_conv = (state_q == sas_pkg::SAS_CONV);
   wire logic soft_go = (state_q == sas_pkg::SAS_WAIT) && ck.rise && converter_enable;
   wire logic conv_start = soft_go || trig_go;
   wire logic [sas_pkg::HC_W-1:0] done_at = sas_pkg::sas_done_at(first_q, auto_q);
   wire logic [sas_pkg::HC_W-1:0] sh_at = sas_pkg::sas_sh_at(first_q, auto_q);
   wire logic [sas_pkg::HC_W-1:0] hc_inc = hc_q + sas_pkg::HC_ONE;
   wire logic done_now = in_conv && pulse && (hc_inc == done_at);
   wire logic sh_now = in_conv && pulse && (hc_inc == sh_at);
   wire logic step_now = in_conv && ck.rise && sar_on_q;
   wire logic last_cycle = in_conv && (hc_q >= done_at - sas_pkg::HC_LAST_CYCLE);

   // Selection buffer: frozen during a conversion until its last converter cycle, nothing applies while disabled
   wire logic track = converter_enable && (!in_conv || last_cycle);
   assign chan_d = track ? channel_gain_select : active_channel;
   assign ref_d = track ? reference_select : ref_q;
   wire logic diff_d = (chan_d >= sas_pkg::SINGLE_ENDED_LIMIT) &&
                       (chan_d != sas_pkg::TEMP_SENSOR_CODE);
   wire logic temp_d = (chan_d == sas_pkg::TEMP_SENSOR_CODE);
   wire logic offs_d = (chan_d == OFFSET_CODE_A) || (chan_d == OFFSET_CODE_B) ||
                       (chan_d == OFFSET_CODE_C);
   wire logic [2:0] ref_oh_d = {ref_d == sas_pkg::REF_INTERNAL, ref_d == sas_pkg::REF_EXTERNAL,
                                ref_d == sas_pkg::REF_SUPPLY};

   // Result alignment; left aligned high byte alone gives 8-bit precision
   assign high_d = left_adjust ? sar_trial_code[9:2] : {6'h00, sar_trial_code[9:8]};
   assign low_d = left_adjust ? {sar_trial_code[1:0], 6'h00} : sar_trial_code[7:0];

   // Next state; clearing the converter enable always forces the idle state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         sas_pkg::SAS_IDLE: begin
            if (trig_go) begin
               state_d = sas_pkg::SAS_CONV;
            end else if (start_write) begin
               state_d = sas_pkg::SAS_WAIT;
            end
         end
         sas_pkg::SAS_WAIT: begin
            if (conv_start) begin
               state_d = sas_pkg::SAS_CONV;
            end
         end
         sas_pkg::SAS_CONV: begin
            if (done_now) begin
               state_d = (free_run || start_write) ? sas_pkg::SAS_WAIT : sas_pkg::SAS_IDLE;
            end
         end
      endcase
      if (!converter_enable) begin
         state_d = sas_pkg::SAS_IDLE;
      end
   end

   // Start bit, done flag and read lock; a set beats a clear, except that a disable clears the start bit
   always_comb begin
      start_d = start_conversion_bit;
      if (done_now && !free_run) begin
         start_d = 1'b0;
      end
      if (start_write || conv_start) begin
         start_d = 1'b1;
      end
      if (!converter_enable) begin
         start_d = 1'b0;
      end
      flag_d = conversion_done_flag;
      if (done_flag_clear) begin
         flag_d = 1'b0;
      end
      if (done_now) begin
         flag_d = 1'b1;
      end
      lock_d = lock_q;
      if (read_high_byte) begin
         lock_d = 1'b0;
      end
      if (read_low_byte) begin
         lock_d = 1'b1;
      end
      first_d = first_q;
      if (done_now) begin
         first_d = 1'b0;
      end
      if (!converter_enable) begin
         first_d = 1'b1;
      end
   end

   // Successive approximation walk, MSB first after the sample point
   always_comb begin
      trial_d = sar_trial_code;
      bit_d = bit_q;
      sar_on_d = sar_on_q;
      hc_d = conv_start ? '0 : ((in_conv && pulse) ? hc_inc : hc_q);
      if (conv_start) begin
         // MSB trial up early; the comparator synchroniser needs time before the first decision
         trial_d = sas_pkg::SAR_MSB_TRIAL;
         sar_on_d = 1'b0;
      end else if (sh_now) begin
         trial_d = sas_pkg::SAR_MSB_TRIAL;
         bit_d = sas_pkg::SAR_MSB_INDEX;
         sar_on_d = 1'b1;
      end else if (step_now) begin
         trial_d[bit_q] = cmp_s2_q;
         if (bit_q != sas_pkg::SAR_LSB_INDEX) begin
            trial_d[bit_q - 4'h1] = 1'b1;
            bit_d = bit_q - 4'h1;
         end else begin
            sar_on_d = 1'b0;
         end
      end
   end

   // Comparator synchroniser, second stage only is used
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else begin
         cmp_s1_q <= comparator_high;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   // Sequencing registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= sas_pkg::SAS_IDLE;
         trig_prev_q <= 1'b0;
         trig_dly_q <= '0;
         hc_q <= '0;
         auto_q <= 1'b0;
         first_q <= 1'b1;
         sar_on_q <= 1'b0;
         bit_q <= '0;
      end else begin
         state_q <= state_d;
         trig_prev_q <= trig_level;
         trig_dly_q <= converter_enable ?
                       {trig_dly_q[sas_pkg::TRIG_SYNC_CYCLES-2:0], trig_take} : '0;
         hc_q <= hc_d;
         auto_q <= conv_start ? trig_go : auto_q;
         first_q <= first_d;
         sar_on_q <= sar_on_d;
         bit_q <= bit_d;
      end
   end

   // Software visible registers; a locked result is dropped
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         start_conversion_bit <= 1'b0;
         conversion_done_flag <= 1'b0;
         lock_q <= 1'b0;
         result_high_byte <= 8'h00;
         result_low_byte <= 8'h00;
      end else begin
         start_conversion_bit <= start_d;
         conversion_done_flag <= flag_d;
         lock_q <= lock_d;
         if (done_now && !lock_q) begin
            result_high_byte <= high_d;
            result_low_byte <= low_d;
         end
      end
   end

   // Front end control registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         analog_enable <= 1'b0;
         sample_hold <= 1'b0;
         sar_trial_code <= '0;
         ref_q <= sas_pkg::REF_SUPPLY;
         reference_onehot <= 3'h1;
         active_channel <= '0;
         differential_mode <= 1'b0;
         gain_select_bit <= 1'b0;
         temp_sensor_route <= 1'b0;
         offset_measure <= 1'b0;
      end else begin
         analog_enable <= converter_enable;
         sample_hold <= sh_now;
         sar_trial_code <= trial_d;
         ref_q <= ref_d;
         reference_onehot <= ref_oh_d;
         active_channel <= chan_d;
         differential_mode <= diff_d;
         gain_select_bit <= diff_d && chan_d[0];
         temp_sensor_route <= temp_d;
         offset_measure <= offs_d && diff_d;
      end
   end

   // Checks on the sequencing
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   a_lock_keeps_result: assert property (lock_q && done_now && !read_low_byte |=> $stable(result_low_byte))
      else $error("result changed while locked");
   a_flag_on_done: assert property (done_now |=> conversion_done_flag)
      else $error("done flag not set at completion");
   a_single_clears: assert property (done_now && !free_run && !start_write && converter_enable |=> !start_conversion_bit)
      else $error("start bit not cleared in single mode");
   a_free_run_holds: assert property (done_now && free_run && converter_enable |=> start_conversion_bit && state_q == sas_pkg::SAS_WAIT)
      else $error("free running did not continue");
   a_start_on_edge: assert property ($rose(in_conv) && !$past(trig_go) |-> $past(ck.rise))
      else $error("software start not on converter rise");
   a_sel_frozen: assert property (in_conv && !last_cycle && $past(in_conv) |-> $stable(active_channel) && $stable(ref_q))
      else $error("selection changed mid conversion");
   a_start_reads_one: assert property (in_conv |-> start_conversion_bit)
      else $error("start bit low during conversion");
   a_trig_latency: assert property (trig_take ##1 converter_enable [*3] |-> trig_go ##1 (in_conv && hc_q == '0))
      else $error("trigger start not three clocks later");
   a_trig_ignored: assert property (in_conv && !done_now |=> !trig_dly_q[0])
      else $error("trigger accepted during conversion");

endmodule
`default_nettype wire

/* File: verification/sas_analog_model.sv */
// Analog front end model: eight input levels and the comparator
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model #(
   parameter logic [9:0] TEMP_LEVEL = 10'h155,
   parameter logic [9:0] OFFSET_LEVEL = 10'h003
) (
   // Input levels, channel 0 in the low bits
   input wire logic [79:0] levels,
   // Front end control
   input wire logic [sas_pkg::RES_W-1:0] sar_trial_code,
   input wire logic [sas_pkg::SEL_W-1:0] active_channel,
   input wire logic temp_sensor_route,
   input wire logic offset_measure,
   // Comparator decision
   output logic comparator_high
);
   logic [9:0] vin;
   // Buffered selection picks the level, so mid-conversion writes cannot leak in
   assign vin = temp_sensor_route ? TEMP_LEVEL :
      (offset_measure ? OFFSET_LEVEL : levels[active_channel[2:0]*10 +: 10]);
   // Level sits half a step above its code, so an equal trial counts as above
   assign comparator_high = (vin >= sar_trial_code);
endmodule
`default_nettype wire

/* File: verification/sas_sequencer_tb_top.sv */
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_tb_top;
   localparam int R = 4;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic converter_enable = 1'b0;
   logic auto_trigger_enable = 1'b0;
   logic left_adjust = 1'b0;
   logic [2:0] prescaler_select = 3'h2;
   logic [2:0] trigger_source_select = 3'h0;
   logic [1:0] reference_select = 2'h0;
   logic [5:0] channel_gain_select = 6'h03;
   logic start_write = 1'b0;
   logic done_flag_clear = 1'b0;
   logic read_low_byte = 1'b0;
   logic read_high_byte = 1'b0;
   logic [7:0] trigger_sources = 8'h00;
   logic [79:0] levels = 80'h0;
   wire logic comparator_high;
   logic [7:0] result_high_byte, result_low_byte;
   logic start_conversion_bit, conversion_done_flag, analog_enable, sample_hold;
   logic [9:0] sar_trial_code;
   logic [2:0] reference_onehot;
   logic [5:0] active_channel;
   logic differential_mode, gain_select_bit, temp_sensor_route, offset_measure;
   int mismatches = 0;
   int n_tests = 0;
   int seed = 93884;
   int n_sh, n_done, cnt, low;
   int exp_q[$];
   logic [9:0] codes [6] = '{{6'h05, 4'h0}, {6'h0c, 4'h8}, {6'h0d, 4'hc},
      {6'h22, 4'h2}, {6'h08, 4'h9}, {6'h09, 4'hd}};

   // 40 MHz clock
   always #12.5 clock = ~clock;

   sas_sequencer DUT (.clock, .nrst, .converter_enable, .auto_trigger_enable, .left_adjust,
      .prescaler_select, .trigger_source_select, .reference_select, .channel_gain_select,
      .start_write, .done_flag_clear, .read_low_byte, .read_high_byte, .trigger_sources,
      .comparator_high, .result_high_byte, .result_low_byte, .start_conversion_bit,
      .conversion_done_flag, .analog_enable, .sample_hold, .sar_trial_code,
      .reference_onehot, .active_channel, .differential_mode, .gain_select_bit,
      .temp_sensor_route, .offset_measure);

   sas_analog_model #(.TEMP_LEVEL(10'h155), .OFFSET_LEVEL(10'h021)) front (.levels,
      .sar_trial_code, .active_channel, .temp_sensor_route, .offset_measure,
      .comparator_high);

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      n_tests++;
      if (seen !== want) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic in_range(input string what, input int v, input int lo, input int hi);
      check(what, 16'(v >= lo && v <= hi), 16'h1);
   endtask

   // Inputs always change 2 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask

   function automatic int lvl(input int ch);
      return int'(levels[ch*10 +: 10]);
   endfunction

   // Bytes must match the last result the model let through
   task automatic check_bytes();
      int w;
      w = left_adjust ? exp_q[$] << 6 : exp_q[$];
      check("result bytes", {result_high_byte, result_low_byte}, w[15:0]);
   endtask

   // Counts cycles to the sample pulse and the done flag; may move the channel midway
   task automatic measure(input int chg);
      logic [5:0] old;
      logic sb;
      n_sh = 0;
      n_done = 0;
      for (int i = 1; i < 400 && n_done == 0; i++) begin
         step(1);
         if (sample_hold === 1'b1 && n_sh == 0) n_sh = i;
         if (conversion_done_flag === 1'b1) n_done = i;
         if (i == 8) sb = start_conversion_bit;
         if (i == 3 * R && chg >= 0) begin
            old = active_channel;
            channel_gain_select = 6'(chg);
         end
         if (i == 3 * R + 3 && chg >= 0) check("held input", 16'(active_channel), 16'(old));
      end
      check("start bit busy", 16'(sb), 16'h1);
      check("done flag", 16'(n_done > 0), 16'h1);
   endtask

   // Software-started conversion; v below zero means the bytes must stay
   task automatic conv(input int cyc, input int sh2, input int v, input int chg);
      pulse(done_flag_clear);
      pulse(start_write);
      measure(chg);
      in_range("sample point", n_sh, sh2 * R / 2, sh2 * R / 2 + R + 3);
      in_range("length", n_done, cyc * R, cyc * R + R + 3);
      check("start bit end", 16'(start_conversion_bit), 16'h0);
      if (v >= 0) exp_q.push_back(v);
      check_bytes();
   endtask

   // Watchdog, far beyond the expected run of about a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      print_verdict();
   end

   // Main sequence
   initial begin
      for (int i = 0; i < 8; i++) levels[i*10 +: 10] = 10'($random(seed));
      step(6);
      nrst = 1'b1;
      converter_enable = 1'b1;
      step(2);
      conv(25, 29, lvl(3), -1);
      channel_gain_select = 6'h01;
      conv(13, 3, lvl(1), 2);
      conv(13, 3, lvl(2), -1);
      // Low byte read locks the bytes until the high byte is read
      pulse(read_low_byte);
      channel_gain_select = 6'h03;
      conv(13, 3, -1, -1);
      pulse(read_high_byte);
      conv(13, 3, lvl(3), -1);
      left_adjust = 1'b1;
      channel_gain_select = 6'h04;
      conv(13, 3, lvl(4), -1);
      // Auto trigger on source 3, then a held level and a stray edge
      left_adjust = 1'b0;
      auto_trigger_enable = 1'b1;
      trigger_source_select = 3'h3;
      pulse(done_flag_clear);
      trigger_sources[3] = 1'b1;
      measure(-1);
      in_range("auto sample", n_sh, 2 * R + 2, 2 * R + 7);
      in_range("auto length", n_done, 27 * R / 2 + 2, 27 * R / 2 + 7);
      exp_q.push_back(lvl(4));
      check_bytes();
      pulse(done_flag_clear);
      step(20 * R);
      check("held trigger", 16'(conversion_done_flag), 16'h0);
      trigger_sources[3] = 1'b0;
      step(1);
      trigger_sources[3] = 1'b1;
      step(4 * R);
      trigger_sources[3] = 1'b0;
      step(1);
      trigger_sources[3] = 1'b1;
      measure(-1);
      pulse(done_flag_clear);
      step(20 * R);
      check("edge in conversion", 16'(conversion_done_flag), 16'h0);
      // Free running, flag never cleared
      trigger_sources = 8'h00;
      trigger_source_select = 3'h0;
      pulse(start_write);
      cnt = 0;
      low = 0;
      repeat (60 * R) begin
         step(1);
         cnt += int'(sample_hold === 1'b1);
         if (start_conversion_bit !== 1'b1) low++;
      end
      in_range("free run count", cnt, 4, 5);
      check("free run start bit", 16'(low), 16'h0);
      // Disabled: selections frozen, prescaler held, conversion dropped
      converter_enable = 1'b0;
      auto_trigger_enable = 1'b0;
      step(2);
      channel_gain_select = 6'h05;
      reference_select = 2'h1;
      cnt = 0;
      repeat (8 * R) begin
         step(1);
         cnt += int'(sample_hold === 1'b1);
      end
      check("frozen selection", 16'({active_channel, reference_onehot}), 16'h0021);
      check("activity while off", 16'(cnt + analog_enable + start_conversion_bit), 16'h0);
      converter_enable = 1'b1;
      for (int r = 0; r < 3; r++) begin
         reference_select = 2'(r);
         step(3);
         check("reference", 16'(reference_onehot), 16'(1 << r));
      end
      check("input after enable", 16'(active_channel), 16'h05);
      check("analog on", 16'(analog_enable), 16'h1);
      foreach (codes[k]) begin
         channel_gain_select = codes[k][9:4];
         step(3);
         check("routing", 16'({differential_mode, gain_select_bit, temp_sensor_route,
            offset_measure}), 16'(codes[k][3:0]));
      end
      conv(25, 29, 32'h21, -1);
      print_verdict();
   end
endmodule
`default_nettype wire
